// >>> dv/host_model.sv
// Purpose: host side that frames opcodes towards the suspend control
// Assumes: one frame at a time, verdict read one cycle after frame end
// Notes: data line shows the inverted byte once released
`timescale 1ns/10ps
`default_nettype none
module host_model
   import susp_pkg::*;
(
   // clock
   input wire logic clk,
   // frame lines
   output logic cs_b,
   output logic byte_valid,
   output logic [7:0] byte_in,
   output susp_pkg::cmd_class_t cmd_class,
   // verdict
   input wire logic cmd_accept
);
   // idle lines from time zero
   initial begin
      cs_b = 1'b1;
      byte_valid = 1'b0;
      byte_in = 8'h00;
      cmd_class = CL_OTHER;
   end
   // opcode, a trailing byte to be ignored, then frame end
   task automatic frame(input logic [7:0] op, input cmd_class_t c, output logic acc);
      @(posedge clk) cs_b <= 1'b0;
      @(posedge clk) begin
         byte_valid <= 1'b1;
         byte_in <= op; // single opcode, no address
      end
      @(posedge clk) byte_in <= op ^ 8'h60; // swaps suspend and resume codes
      @(posedge clk) begin
         byte_valid <= 1'b0;
         byte_in <= ~op;
         cs_b <= 1'b1;
         cmd_class <= c;
      end
      // verdict stands for one cycle only, from the clock edge after the frame-end edge
      @(posedge clk);
      #1 acc = cmd_accept;
   endtask
endmodule
`default_nettype wire

// >>> dv/susp_ctl_asserts.sv
// Purpose: concurrent checks on the suspend and resume control
// Assumes: latency parameters handed on by the bind
// Notes: first opcode and pending resume tracked in local helpers
`timescale 1ns/10ps
`default_nettype none
module susp_ctl_checker
   import susp_pkg::*;
#(
   parameter int RES_CYCLES = 4,
   parameter int SUSP_CYCLES = 4
) (
   // clock and resets
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reset_pin_b,
   // frame
   input wire logic cs_b,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   input wire susp_pkg::cmd_class_t cmd_class,
   // engines
   input wire logic prog_active,
   input wire logic prog_buf2,
   input wire logic erase_active,
   input wire logic prog_hold,
   input wire logic erase_hold,
   input wire logic op_abort,
   // verdict and status
   input wire logic cmd_accept,
   input wire logic cmd_reject,
   input wire logic rdy_busy_b,
   input wire logic buf1_program_suspended_flag,
   input wire logic buf2_program_suspended_flag,
   input wire logic erase_suspended_flag
);
   localparam int RES_LIM = RES_CYCLES + 4;
   localparam int SUSP_LIM = SUSP_CYCLES + 4;
   logic seen_r;
   logic pend_r;
   logic [7:0] op_r;
   logic [2:0] flg_r;
   wire logic [2:0] flg = {buf1_program_suspended_flag, buf2_program_suspended_flag,
      erase_suspended_flag};
   wire logic vd = cmd_accept | cmd_reject;
   wire logic pf = buf1_program_suspended_flag | buf2_program_suspended_flag;
   wire logic op_cmd = (op_r != OPC_SUSPEND) && (op_r != OPC_RESUME);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // first byte of a frame; a resume stays pending until some flag drops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_r <= 1'b0;
         pend_r <= 1'b0;
         op_r <= 8'h00;
         flg_r <= 3'h0;
      end else begin
         seen_r <= !cs_b && (seen_r || byte_valid);
         if (!cs_b && byte_valid && !seen_r)
            op_r <= byte_in;
         flg_r <= flg;
         pend_r <= (pend_r || (cmd_accept && op_r == OPC_RESUME)) && !(|(flg_r & ~flg));
      end
   end
   verdict_time_a: assert property ($rose(cs_b) && seen_r |=> cmd_accept ^ cmd_reject)
      else $error("no single verdict after frame end");
   susp_flag_a: assert property (cmd_accept && op_r == OPC_SUSPEND && prog_active &&
      !prog_buf2 |-> ##[1:SUSP_LIM] (buf1_program_suspended_flag && prog_hold || !prog_active))
      else $error("program suspend did not set buffer 1 flag");
   susp_ready_a: assert property ($rose(pf) |-> ##[0:1] rdy_busy_b)
      else $error("ready missing after program suspend");
   res_busy_a: assert property (cmd_accept && op_r == OPC_RESUME |-> !rdy_busy_b)
      else $error("busy missing after resume");
   res_clear_a: assert property (cmd_accept && op_r == OPC_RESUME && pf
      |-> ##[1:RES_LIM] !pf && !prog_hold)
      else $error("program flag not cleared by resume");
   dual_keep_a: assert property (cmd_accept && op_r == OPC_RESUME && pf &&
      erase_suspended_flag |-> erase_hold throughout (##[1:RES_LIM] !pf))
      else $error("erase released during program resume");
   susp_ignore_a: assert property (vd && op_r == OPC_SUSPEND && pend_r |-> cmd_reject)
      else $error("suspend taken while resuming");
   refuse_cmd_a: assert property (vd && op_cmd && $past(|flg) &&
      $past(cmd_class) inside {CL_PROT_ENABLE, CL_PROT_DISABLE, CL_PROT_REG_ERASE,
      CL_PROT_REG_PROG, CL_LOCKDOWN, CL_FREEZE_LOCK, CL_SEC_PROG, CL_DPD_ENTER,
      CL_DPD_EXIT, CL_UDPD_ENTER} |-> cmd_reject)
      else $error("forbidden command accepted in suspend");
   xfer_gate_a: assert property (vd && op_cmd &&
      ($past(buf1_program_suspended_flag) && $past(cmd_class) inside {CL_XFER_BUF1, CL_CMP_BUF1}
      || $past(buf2_program_suspended_flag) && $past(cmd_class) inside {CL_XFER_BUF2,
      CL_CMP_BUF2}) |-> cmd_reject)
      else $error("transfer to suspended buffer accepted");
   reads_ok_a: assert property (vd && op_cmd && $past(cmd_class) inside {
      CL_PROT_REG_READ, CL_LOCKDOWN_READ, CL_SEC_READ, CL_CFG_READ, CL_STATUS_READ,
      CL_ID_READ, CL_RESET} |-> cmd_accept)
      else $error("permitted command refused");
   pin_reset_a: assert property (!reset_pin_b |=> flg == 3'h0 && !prog_hold && !erase_hold)
      else $error("reset pin left suspend state");
   cover property (vd && $past(|flg) && cmd_reject);
   cover property ($rose(erase_suspended_flag));
   cover property (cmd_accept && op_r == OPC_RESUME && pf && erase_suspended_flag);
endmodule
bind flash_suspend_resume_control susp_ctl_checker #(
   .RES_CYCLES(RES_CYCLES), .SUSP_CYCLES(SUSP_CYCLES)
) chk_inst (
   .clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b), .cs_b(cs_b),
   .byte_valid(byte_valid), .byte_in(byte_in), .cmd_class(cmd_class),
   .prog_active(prog_active), .prog_buf2(prog_buf2), .erase_active(erase_active),
   .prog_hold(prog_hold), .erase_hold(erase_hold), .op_abort(op_abort),
   .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .rdy_busy_b(rdy_busy_b),
   .buf1_program_suspended_flag(buf1_program_suspended_flag),
   .buf2_program_suspended_flag(buf2_program_suspended_flag),
   .erase_suspended_flag(erase_suspended_flag)
);
`default_nettype wire

// >>> dv/test_flash_suspend_resume_control.sv
// Purpose: directed tests of suspend, resume and command gating
// Assumes: short latencies through the design parameters
// Notes: engines are level inputs driven from the main sequence
`timescale 1ns/10ps
`default_nettype none
module test_flash_suspend_resume_control
   import susp_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reset_pin_b = 1'b1;
   logic prog_active = 1'b0;
   logic prog_buf2 = 1'b0;
   logic erase_active = 1'b0;
   logic cs_b, byte_valid, acc, prog_hold, erase_hold, op_abort;
   logic cmd_accept, cmd_reject, rdy_busy_b, f1, f2, fe;
   logic [7:0] byte_in;
   cmd_class_t cmd_class;
   int err_count = 0;
   int n_tests = 0;
   int n_abort = 0;
   wire logic [2:0] flg = {f1, f2, fe};
   flash_suspend_resume_control #(.RES_CYCLES(12), .SUSP_CYCLES(4))
      flash_suspend_resume_control_inst (
      .clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b), .cs_b(cs_b),
      .byte_valid(byte_valid), .byte_in(byte_in), .cmd_class(cmd_class),
      .prog_active(prog_active), .prog_buf2(prog_buf2), .erase_active(erase_active),
      .prog_hold(prog_hold), .erase_hold(erase_hold), .op_abort(op_abort),
      .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .rdy_busy_b(rdy_busy_b),
      .buf1_program_suspended_flag(f1), .buf2_program_suspended_flag(f2),
      .erase_suspended_flag(fe));
   host_model host_model_inst (.clk(clk), .cs_b(cs_b), .byte_valid(byte_valid),
      .byte_in(byte_in), .cmd_class(cmd_class), .cmd_accept(cmd_accept));
   always #20 clk = ~clk;
   // count engine aborts, a resume must never cause one
   always @(posedge clk) if (op_abort === 1'b1) n_abort++;
   task automatic cmp(input string what, input logic [2:0] exp, input logic [2:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic send(input logic [7:0] op, input cmd_class_t c, input logic exp);
      host_model_inst.frame(op, c, acc);
      cmp($sformatf("verdict %h %s", op, c.name()), {1'b0, exp, !exp}, {1'b0, acc, cmd_reject});
   endtask
   // poll the flags under a bound, as the host would
   task automatic waitf(input logic [2:0] exp);
      for (int i = 0; i < 60 && flg !== exp; i++) begin
         @(posedge clk);
         #1;
      end
      cmp("flags", exp, flg);
   endtask
   // every class but CL_RESET against the suspend state s1/s2 (erase alone: both low)
   task automatic tbl(input logic s1, input logic s2);
      cmd_class_t c;
      for (int k = 6'h00; k <= 6'h25; k++) begin
         c = cmd_class_t'(k);
         send(8'h3d, c, c inside {CL_READ_ARRAY, CL_READ_BUF1, CL_READ_BUF2, CL_PROT_REG_READ,
            CL_LOCKDOWN_READ, CL_SEC_READ, CL_CFG_READ, CL_STATUS_READ, CL_ID_READ}
            || !s1 && c inside {CL_XFER_BUF1, CL_CMP_BUF1, CL_BUF1_WRITE}
            || !s2 && c inside {CL_XFER_BUF2, CL_CMP_BUF2, CL_BUF2_WRITE}
            || !(s1 | s2) && c inside {CL_B1_PROG_NOERASE, CL_B2_PROG_NOERASE,
            CL_MP_B1_NOERASE});
      end
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      $display("[ERR] watchdog expired");
      results();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1 cmp("idle", 3'h1, {flg[2:1] | flg[0], rdy_busy_b});
      // program through buffer 1: suspend, gating, resume
      @(posedge clk) prog_active <= 1'b1;
      send(OPC_SUSPEND, CL_OTHER, 1'b1);
      waitf(3'h4);
      cmp("hold ready", 3'h3, {1'b0, prog_hold, rdy_busy_b});
      tbl(1'b1, 1'b0);
      waitf(3'h4);
      send(OPC_RESUME, CL_OTHER, 1'b1);
      cmp("busy", 3'h0, {2'h0, rdy_busy_b});
      send(OPC_SUSPEND, CL_OTHER, 1'b0);
      waitf(3'h0);
      cmp("running", 3'h0, {1'b0, prog_hold, rdy_busy_b});
      @(posedge clk) prog_active <= 1'b0;
      $display("test program suspend done");
      // erase suspend, then a program suspend on top of it
      @(posedge clk) erase_active <= 1'b1;
      send(OPC_SUSPEND, CL_OTHER, 1'b1);
      waitf(3'h1);
      tbl(1'b0, 1'b0);
      @(posedge clk) begin
         prog_active <= 1'b1;
         prog_buf2 <= 1'b1;
      end
      send(OPC_SUSPEND, CL_OTHER, 1'b1);
      waitf(3'h3);
      send(OPC_RESUME, CL_OTHER, 1'b1);
      waitf(3'h1);
      cmp("erase hold", 3'h1, {2'h0, erase_hold});
      @(posedge clk) prog_active <= 1'b0;
      send(OPC_RESUME, CL_OTHER, 1'b1);
      waitf(3'h0);
      cmp("erase run", 3'h0, {1'b0, erase_hold, rdy_busy_b});
      cmp("no abort", 3'h0, n_abort[2:0]);
      $display("test dual suspend done");
      // reset by command and by pin while erase suspended
      send(OPC_SUSPEND, CL_OTHER, 1'b1);
      waitf(3'h1);
      send(8'hf0, CL_RESET, 1'b1);
      waitf(3'h0);
      send(OPC_SUSPEND, CL_OTHER, 1'b1);
      waitf(3'h1);
      @(posedge clk) reset_pin_b <= 1'b0;
      @(posedge clk) reset_pin_b <= 1'b1;
      waitf(3'h0);
      repeat (2) @(posedge clk);
      cmp("aborts", 3'h2, n_abort[2:0]);
      $display("test reset done");
      results();
   end
endmodule
`default_nettype wire

// >>> rtl/flash_suspend_resume_control.sv
// Purpose: suspend, resume and command gating for the program/erase engines
// Assumes: spi bytes and chip select are synchronous to clk
// Notes: engines freeze in place while their hold output is high
`timescale 1ns/10ps
`default_nettype none
module flash_suspend_resume_control
   import susp_pkg::*;
#(
   parameter int RES_CYCLES = susp_pkg::RESUME_CYC,
   parameter int SUSP_CYCLES = susp_pkg::SUSPEND_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // hardware reset pin, synchronous, active low
   input wire logic reset_pin_b,
   // spi frame
   input wire logic cs_b,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   // class of the frame from the command decoder, valid at frame end
   input wire susp_pkg::cmd_class_t cmd_class,
   // engine state
   input wire logic prog_active,
   input wire logic prog_buf2,
   input wire logic erase_active,
   // engine control
   output logic prog_hold,
   output logic erase_hold,
   output logic op_abort,
   // command verdict, one pulse per frame
   output logic cmd_accept,
   output logic cmd_reject,
   // status register bits
   output logic rdy_busy_b,
   output logic buf1_program_suspended_flag,
   output logic buf2_program_suspended_flag,
   output logic erase_suspended_flag
);
   ctl_state_t state_r;
   ctl_state_t state_nxt;
   logic cs_b_d_r;
   logic first_byte_r;
   logic [7:0] opcode_r;
   logic opcode_seen_r;
   logic frame_end;
   logic is_suspend;
   logic is_resume;
   logic is_reset;
   logic any_susp;
   logic prog_running;
   logic erase_running;
   logic tgt_prog_r;
   logic tgt_buf2_r;
   logic susp_start;
   logic res_start;
   logic susp_done;
   logic res_done;
   logic susp_run;
   logic res_run;
   logic hard_reset;

   // permission in a suspend state; no suspend means everything passes
   function automatic logic cmd_allowed(input cmd_class_t c, input logic s1,
                                        input logic s2, input logic se);
      logic ok;
      ok = 1'b1;
      if (s1 | s2 | se) begin
         case (c)
            CL_READ_ARRAY, CL_READ_BUF1, CL_READ_BUF2: ok = 1'b1;
            CL_BUF1_WRITE: ok = !s1;
            CL_BUF2_WRITE: ok = !s2;
            CL_B1_PROG_NOERASE, CL_B2_PROG_NOERASE, CL_MP_B1_NOERASE:
               ok = !(s1 | s2);
            CL_B1_PROG_ERASE, CL_B2_PROG_ERASE, CL_MP_B1_ERASE, CL_MP_B2_ERASE,
            CL_AUTO_REWRITE, CL_PAGE_ERASE, CL_BLOCK_ERASE, CL_SECTOR_ERASE,
            CL_CHIP_ERASE: ok = 1'b0;
            CL_PROT_ENABLE, CL_PROT_DISABLE, CL_PROT_REG_ERASE, CL_PROT_REG_PROG,
            CL_LOCKDOWN, CL_FREEZE_LOCK, CL_SEC_PROG: ok = 1'b0; // [R10]
            CL_PROT_REG_READ, CL_LOCKDOWN_READ, CL_SEC_READ: ok = 1'b1; // [R11]
            CL_XFER_BUF1, CL_CMP_BUF1: ok = !s1; // [R12]
            CL_XFER_BUF2, CL_CMP_BUF2: ok = !s2; // [R13]
            CL_DPD_ENTER, CL_DPD_EXIT, CL_UDPD_ENTER: ok = 1'b0; // [R14]
            CL_CFG_READ, CL_STATUS_READ, CL_ID_READ: ok = 1'b1; // [R15]
            CL_RESET: ok = 1'b1; // [R16]
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // frame end is the rising edge of chip select
   assign frame_end = !cs_b_d_r && cs_b;
   // only the first byte counts, later ones are dropped
   assign is_suspend = opcode_seen_r && (opcode_r == OPC_SUSPEND); // [R17]
   assign is_resume = opcode_seen_r && (opcode_r == OPC_RESUME); // [R1]
   assign is_reset = frame_end && !is_suspend && !is_resume && (cmd_class == CL_RESET);
   assign hard_reset = !reset_pin_b || is_reset; // [R16]
   assign any_susp = buf1_program_suspended_flag || buf2_program_suspended_flag ||
      erase_suspended_flag;
   assign prog_running = prog_active && !prog_hold;
   assign erase_running = erase_active && !erase_hold;

   // suspend taken only when idle and something runs; pending resume blocks it
   assign susp_start = frame_end && is_suspend && (state_r == ST_IDLE) &&
      (prog_running || erase_running) && !hard_reset; // [R8]
   // resume taken at frame end when a flag is set and nothing runs
   assign res_start = frame_end && is_resume && (state_r == ST_IDLE) && any_susp &&
      !prog_running && !erase_running && !hard_reset; // [R2]

   // frame tracking
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_b_d_r <= 1'b1;
         first_byte_r <= 1'b1;
         opcode_r <= 8'h00;
         opcode_seen_r <= 1'b0;
      end else begin
         cs_b_d_r <= cs_b;
         if (cs_b) begin
            first_byte_r <= 1'b1;
            if (frame_end) begin
               opcode_seen_r <= 1'b0;
            end
         end else if (byte_valid && first_byte_r) begin
            opcode_r <= byte_in;
            opcode_seen_r <= 1'b1;
            first_byte_r <= 1'b0;
         end
      end
   end

   // target of a suspend or resume, fixed when it is taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tgt_prog_r <= 1'b0;
         tgt_buf2_r <= 1'b0;
      end else if (susp_start) begin
         tgt_prog_r <= prog_running;
         tgt_buf2_r <= prog_buf2;
      end else if (res_start) begin
         // program first when both are suspended
         tgt_prog_r <= buf1_program_suspended_flag || buf2_program_suspended_flag; // [R6]
         tgt_buf2_r <= buf2_program_suspended_flag;
      end
   end

   // latency timers; the count is the limit, not a typical time
   latency_timer #(.W(TMR_W)) u_susp_tmr (
      .clk(clk),
      .rst_b(rst_b),
      .start(susp_start),
      .abort(hard_reset),
      .load(TMR_W'(SUSP_CYCLES)),
      .running(susp_run),
      .done(susp_done)
   );

   latency_timer #(.W(TMR_W)) u_res_tmr (
      .clk(clk),
      .rst_b(rst_b),
      .start(res_start),
      .abort(hard_reset),
      .load(TMR_W'(RES_CYCLES)),
      .running(res_run),
      .done(res_done)
   );

   // sequencing state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (susp_start) begin
               state_nxt = ST_SUSPENDING;
            end else if (res_start) begin
               state_nxt = ST_RESUMING;
            end
         end
         ST_SUSPENDING: begin
            if (susp_done || !susp_run) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RESUMING: begin
            if (res_done || !res_run) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (hard_reset) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // engine holds; releasing a hold lets the engine continue in place
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_hold <= 1'b0;
         erase_hold <= 1'b0;
      end else if (hard_reset) begin
         prog_hold <= 1'b0;
         erase_hold <= 1'b0;
      end else if (susp_done && state_r == ST_SUSPENDING) begin
         if (tgt_prog_r && prog_active) begin
            prog_hold <= 1'b1;
         end else if (!tgt_prog_r && erase_active) begin
            erase_hold <= 1'b1;
         end
      end else if (res_done && state_r == ST_RESUMING) begin
         if (tgt_prog_r) begin
            prog_hold <= 1'b0; // [R3]
         end else begin
            erase_hold <= 1'b0; // [R3]
         end
      end
   end

   // suspend flags; suspend and resume never land in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buf1_program_suspended_flag <= 1'b0;
         buf2_program_suspended_flag <= 1'b0;
         erase_suspended_flag <= 1'b0;
      end else if (hard_reset) begin
         // reset aborts the suspended work, so flags drop
         buf1_program_suspended_flag <= 1'b0;
         buf2_program_suspended_flag <= 1'b0;
         erase_suspended_flag <= 1'b0;
      end else if (susp_done && state_r == ST_SUSPENDING) begin
         if (tgt_prog_r && prog_active) begin
            buf1_program_suspended_flag <= buf1_program_suspended_flag || !tgt_buf2_r; // [R18]
            buf2_program_suspended_flag <= buf2_program_suspended_flag || tgt_buf2_r; // [R18]
         end else if (!tgt_prog_r && erase_active) begin
            erase_suspended_flag <= 1'b1; // [R18]
         end
      end else if (res_done && state_r == ST_RESUMING) begin
         if (tgt_prog_r) begin
            // erase stays suspended until a second resume
            if (tgt_buf2_r) begin
               buf2_program_suspended_flag <= 1'b0; // [R4]
            end else begin
               buf1_program_suspended_flag <= 1'b0; // [R4]
            end
         end else begin
            erase_suspended_flag <= 1'b0; // [R4] [R7]
         end
      end
   end

   // ready/busy: busy while an engine runs or a resume is pending
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdy_busy_b <= 1'b1;
      end else if (hard_reset) begin
         rdy_busy_b <= 1'b1;
      end else if (state_nxt == ST_RESUMING) begin
         rdy_busy_b <= 1'b0; // [R5]
      end else if (res_done && state_r == ST_RESUMING) begin
         rdy_busy_b <= 1'b0; // [R5]
      end else if (susp_done && state_r == ST_SUSPENDING) begin
         rdy_busy_b <= 1'b1; // [R18]
      end else begin
         rdy_busy_b <= !(prog_running || erase_running);
      end
   end

   // verdict per frame; a refused frame touches no flag or content
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_accept <= 1'b0;
         cmd_reject <= 1'b0;
         op_abort <= 1'b0;
      end else begin
         cmd_accept <= 1'b0;
         cmd_reject <= 1'b0;
         op_abort <= hard_reset && (any_susp || prog_active || erase_active);
         if (frame_end && opcode_seen_r) begin
            if (is_suspend) begin
               cmd_accept <= susp_start;
               cmd_reject <= !susp_start; // [R8]
            end else if (is_resume) begin
               cmd_accept <= res_start;
               cmd_reject <= !res_start;
            end else if (cmd_allowed(cmd_class, buf1_program_suspended_flag,
                                     buf2_program_suspended_flag,
                                     erase_suspended_flag)) begin
               cmd_accept <= 1'b1;
            end else begin
               cmd_reject <= 1'b1; // [R19]
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/latency_timer.sv
// Purpose: one-shot down counter that marks the end of a latency
// Assumes: start is a one-cycle pulse; load value at least one
// Notes: a restart while running reloads the count
`timescale 1ns/10ps
`default_nettype none
module latency_timer #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic [W-1:0] load,
   // status
   output logic running,
   output logic done
);
   logic [W-1:0] cnt_r;

   // counter; abort wins so a reset never leaves a stale done
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            running <= 1'b0;
         end else if (start) begin
            cnt_r <= load - {{(W-1){1'b0}}, 1'b1};
            running <= 1'b1;
         end else if (running) begin
            if (cnt_r == '0) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/susp_pkg.sv
// Purpose: constants and types for the suspend and resume control
// Assumes: clk at 25 MHz; command classes come from an outside decoder
// Notes on behaviour
// R1 - resume opcode d0, trailing bytes ignored
// R2 - resume starts within resume latency after frame
// R3 - resumed operation continues from its pause point
// R4 - resume clears the matching suspend flag
// R5 - busy reported while resumed operation runs
// R6 - dual suspend: resume restarts program only
// R7 - host resumes again for the erase
// R8 - suspend ignored while a resume is pending
// R9 - host waits or polls before suspending again
// R10 - protection, lockdown, security program refused
// R11 - protection, lockdown, security reads accepted
// R12 - buffer 1 transfer/compare refused in ps1
// R13 - buffer 2 transfer/compare refused in ps2
// R14 - power-down entry and exit refused
// R15 - config, status, id reads accepted
// R16 - reset by command or pin accepted
// R17 - suspend opcode b0, trailing bytes ignored
// R18 - suspend sets matching flag and reports ready
// R19 - refused command dropped, flags unchanged
package susp_pkg;
   localparam logic [7:0] OPC_SUSPEND = 8'hb0;
   localparam logic [7:0] OPC_RESUME = 8'hd0;
   localparam int CLK_PERIOD_NS = 40;
   // latency limits in ns, plain defaults
   localparam int RESUME_LATENCY_LIMIT_NS = 20000;
   localparam int SUSPEND_LATENCY_LIMIT_NS = 20000;
   // longest times round down, never below one cycle
   localparam int RESUME_CYC = (RESUME_LATENCY_LIMIT_NS / CLK_PERIOD_NS < 1) ? 1 :
      RESUME_LATENCY_LIMIT_NS / CLK_PERIOD_NS;
   localparam int SUSPEND_CYC = (SUSPEND_LATENCY_LIMIT_NS / CLK_PERIOD_NS < 1) ? 1 :
      SUSPEND_LATENCY_LIMIT_NS / CLK_PERIOD_NS;
   localparam int TMR_W = 16;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SUSPENDING = 2'b01,
      ST_RESUMING = 2'b10
   } ctl_state_t;

   typedef enum logic [5:0] {
      CL_OTHER = 6'h00, CL_READ_ARRAY = 6'h01, CL_READ_BUF1 = 6'h02,
      CL_READ_BUF2 = 6'h03, CL_BUF1_WRITE = 6'h04, CL_BUF2_WRITE = 6'h05,
      CL_B1_PROG_ERASE = 6'h06, CL_B2_PROG_ERASE = 6'h07,
      CL_B1_PROG_NOERASE = 6'h08, CL_B2_PROG_NOERASE = 6'h09,
      CL_MP_B1_ERASE = 6'h0a, CL_MP_B2_ERASE = 6'h0b, CL_MP_B1_NOERASE = 6'h0c,
      CL_AUTO_REWRITE = 6'h0d, CL_PAGE_ERASE = 6'h0e, CL_BLOCK_ERASE = 6'h0f,
      CL_SECTOR_ERASE = 6'h10, CL_CHIP_ERASE = 6'h11, CL_PROT_ENABLE = 6'h12,
      CL_PROT_DISABLE = 6'h13, CL_PROT_REG_ERASE = 6'h14, CL_PROT_REG_PROG = 6'h15,
      CL_PROT_REG_READ = 6'h16, CL_LOCKDOWN = 6'h17, CL_LOCKDOWN_READ = 6'h18,
      CL_FREEZE_LOCK = 6'h19, CL_SEC_PROG = 6'h1a, CL_SEC_READ = 6'h1b,
      CL_XFER_BUF1 = 6'h1c, CL_XFER_BUF2 = 6'h1d, CL_CMP_BUF1 = 6'h1e,
      CL_CMP_BUF2 = 6'h1f, CL_DPD_ENTER = 6'h20, CL_DPD_EXIT = 6'h21,
      CL_UDPD_ENTER = 6'h22, CL_CFG_READ = 6'h23, CL_STATUS_READ = 6'h24,
      CL_ID_READ = 6'h25, CL_RESET = 6'h26
   } cmd_class_t;
endpackage
